// ### pkg/pms_params.svh
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH
`define PMS_CLK_NS      20
`define PMS_CYC_PER_US  (1000 / `PMS_CLK_NS)
`define PMS_T_START_MS  10
`define PMS_T_U1_00_US  1600
`define PMS_T_U1_01_US  5000
`define PMS_T_U1_10_US  25000
`define PMS_T_U1_11_US  125000
`define PMS_T_U4_00_US  500
`define PMS_T_U4_01_US  1500
`define PMS_T_U4_10_US  6500
`define PMS_T_U4_11_US  32000
`define PMS_T_S1N_BR_US 1500
`define PMS_T_S1N_FU_US 4500
`define PMS_T_S1L_BR_US 5500
`define PMS_T_S1L_FU_US 12000
`define PMS_T_S4N_BR_US 500
`define PMS_T_S4N_FU_US 1500
`define PMS_T_S4L_BR_US 1500
`define PMS_T_S4L_FU_US 4500
`define PMS_T_WAKE_LOW_US 8
`define PMS_WAKE_LOW_CYC (`PMS_T_WAKE_LOW_US * `PMS_CYC_PER_US)
`define PMS_SPC_00 8'hff
`define PMS_SPC_01 8'h7f
`define PMS_SPC_10 8'h1f
`define PMS_SPC_11 8'h0f
`define PMS_STAT_VALID 2'h0
`define PMS_STAT_STALE 2'h2
`define PMS_RATE_FAST  2'h0
`endif

// ### pkg/pms_pkg.sv
package pms_pkg;
   typedef enum logic [1:0] {st_startup, st_convert, st_pdown, st_sleep} pms_state_e;
   typedef struct packed {
      logic       sleep_mode;
      logic       clk_4m;
      logic       long_int;
      logic       two_wire;
      logic [1:0] rate;
   } pms_cfg_s;
   typedef struct packed {
      logic [1:0]  status;
      logic [13:0] bridge;
      logic [10:0] temp;
   } pms_packet_s;
   typedef logic [23:0] pms_tmr_t;
endpackage

// ### hdl/pms_sequencer.sv
`timescale 1ns/100ps
`include "pms_params.svh"
// Contract
// - wait ten milliseconds before any conversion
// - first corrected result follows start-up window
// - factory mode: periodic or host-commanded
// - fastest rate back to back, else power-down
// - after power-down: bridge, correct, write, sleep
// - special measurement every 255/127/31/15 cycles
// - update periods per rate and core clock
// - times typical; worst case is times 1.15
// - rate code 00 by default
// - special cycle longer by one conversion
// - fetch of valid output makes status stale
// - two-wire: interrupt rises on new valid data
// - low-power mode sleeps until a wake command
// - full wake measures all, bridge wake reuses
// - fetch reports valid, then stale once done
// - fetch during measurement returns stale status (done in low-power mode only)
// - normal-integration sleep response times
// - long-integration sleep response times
// - output invalid until first measurement written
// - packet: status, bridge, optional temperature
module pms_sequencer
   import pms_pkg::*;
#(
   parameter int unsigned START_CYC = `PMS_T_START_MS * 1000 * `PMS_CYC_PER_US,
   parameter int unsigned UPD1_CYC [4] = '{`PMS_T_U1_00_US * `PMS_CYC_PER_US, `PMS_T_U1_01_US * `PMS_CYC_PER_US,
                                         `PMS_T_U1_10_US * `PMS_CYC_PER_US, `PMS_T_U1_11_US * `PMS_CYC_PER_US},
   parameter int unsigned UPD4_CYC [4] = '{`PMS_T_U4_00_US * `PMS_CYC_PER_US, `PMS_T_U4_01_US * `PMS_CYC_PER_US,
                                         `PMS_T_U4_10_US * `PMS_CYC_PER_US, `PMS_T_U4_11_US * `PMS_CYC_PER_US},
   parameter int unsigned SLP_CYC [8]  = '{`PMS_T_S1N_BR_US * `PMS_CYC_PER_US, `PMS_T_S1N_FU_US * `PMS_CYC_PER_US,
                                         `PMS_T_S1L_BR_US * `PMS_CYC_PER_US, `PMS_T_S1L_FU_US * `PMS_CYC_PER_US,
                                         `PMS_T_S4N_BR_US * `PMS_CYC_PER_US, `PMS_T_S4N_FU_US * `PMS_CYC_PER_US,
                                         `PMS_T_S4L_BR_US * `PMS_CYC_PER_US, `PMS_T_S4L_FU_US * `PMS_CYC_PER_US}
) (
   // clock and reset
   input  wire logic                clock_in,
   input  wire logic                reset_in,
   // factory configuration
   input  wire pms_pkg::pms_cfg_s   cfg_in,
   // converter results
   input  wire logic [13:0]         bridge_code_in,
   input  wire logic [10:0]         temp_code_in,
   // two-wire commands from framing logic
   input  wire logic                wake_full_measure_read_in,
   input  wire logic                wake_bridge_only_write_in,
   input  wire logic                result_fetch_done_in,
   // spi pins
   input  wire logic                spi_clk_pin_in,
   input  wire logic                int_ss_pin_in,
   output logic                     int_ss_out,
   output logic                     int_ss_oe_out,
   // sequencer status
   output pms_pkg::pms_packet_s     result_packet_out,
   output logic                     result_write_out,
   output logic                     analog_on_out,
   output logic                     special_meas_out
);
   import pms_pkg::*;

   pms_state_e  state_r, state_nxt;
   pms_tmr_t    tmr_r, tmr_nxt;
   logic        special_r, special_nxt;
   logic [7:0]  spc_cnt_r, spc_cnt_nxt;
   logic [1:0]  status_r, status_nxt;
   logic [13:0] bridge_r;
   logic [10:0] temp_r;
   pms_packet_s pkt_r;
   logic        int_r;
   // pin synchronisers: bit 1 slave select, bit 0 spi clock
   logic [1:0]  sync1_r, sync2_r, sync3_r, pin_r, pin_d_r;
   logic [8:0]  ss_low_cnt_r;
   logic        sclk_seen_r;

   wire         tmr_done   = (tmr_r == '0);
   wire         upd_mode   = !cfg_in.sleep_mode;
   wire         cmd_ok     = (state_r != st_startup);
   wire         wr         = (state_r == st_convert) && tmr_done;
   wire         ss_rise    = pin_r[1] && !pin_d_r[1];
   wire         sclk_edge  = pin_r[0] != pin_d_r[0];
   wire         spi_mode   = !cfg_in.two_wire;
   wire         spi_fetch  = spi_mode && ss_rise && sclk_seen_r;
   wire         spi_wake   = spi_mode && ss_rise && !sclk_seen_r && (ss_low_cnt_r >= 9'(`PMS_WAKE_LOW_CYC));
   wire         wake_full  = cmd_ok && ((cfg_in.two_wire && wake_full_measure_read_in) || spi_wake);
   wire         wake_br    = cmd_ok && cfg_in.two_wire && wake_bridge_only_write_in;
   wire         fetch_done = cmd_ok && ((cfg_in.two_wire && result_fetch_done_in) || spi_fetch);
   wire [23:0]  conv_cyc   = cfg_in.clk_4m ? 24'(UPD4_CYC[0]) : 24'(UPD1_CYC[0]);
   wire [23:0]  period_cyc = cfg_in.clk_4m ? 24'(UPD4_CYC[cfg_in.rate]) : 24'(UPD1_CYC[cfg_in.rate]);
   wire [2:0]   slp_idx    = {cfg_in.clk_4m, cfg_in.long_int, wake_full};
   wire [23:0]  slp_len    = 24'(SLP_CYC[slp_idx]) - 24'h1;
   wire [23:0]  conv_len   = special_nxt ? (conv_cyc + conv_cyc - 24'h1) : (conv_cyc - 24'h1);
   wire [23:0]  pdown_len  = period_cyc - conv_cyc - 24'h1;
   wire [7:0]   spc_limit  = (cfg_in.rate == 2'h0) ? `PMS_SPC_00 :
                             (cfg_in.rate == 2'h1) ? `PMS_SPC_01 :
                             (cfg_in.rate == 2'h2) ? `PMS_SPC_10 : `PMS_SPC_11;
   // the write cycle itself is not busy, so the fresh result shows valid at once
   wire         sleep_busy = cfg_in.sleep_mode && (state_r == st_convert) && !wr;
   // bypass so the packet carries this write's codes, not the previous ones
   wire [13:0]  bridge_now = wr ? bridge_code_in : bridge_r;
   wire [10:0]  temp_now   = (wr && special_r) ? temp_code_in : temp_r;

   // special measurement scheduling; the first update cycle is always special
   always_comb begin
      special_nxt = special_r;
      spc_cnt_nxt = spc_cnt_r;
      if (upd_mode && wr) begin
         spc_cnt_nxt = special_r ? 8'h00 : spc_cnt_r + 8'h01;
         special_nxt = !special_r && (spc_cnt_r == spc_limit - 8'h01);
      end else if (state_r == st_sleep && (wake_full || wake_br)) begin
         special_nxt = wake_full;
      end
   end

   always_comb begin
      state_nxt = state_r;
      tmr_nxt   = tmr_done ? tmr_r : tmr_r - 24'h1;
      unique case (state_r)
         st_startup: begin
            if (tmr_done) begin
               if (cfg_in.sleep_mode) begin
                  state_nxt = st_sleep;
               end else begin
                  state_nxt = st_convert;
                  tmr_nxt   = conv_len;
               end
            end
         end
         st_convert: begin
            if (tmr_done) begin
               if (cfg_in.sleep_mode) begin
                  state_nxt = st_sleep;
               end else if (cfg_in.rate == `PMS_RATE_FAST) begin
                  tmr_nxt = conv_len;
               end else begin
                  state_nxt = st_pdown;
                  tmr_nxt   = pdown_len;
               end
            end
         end
         st_pdown: begin
            if (tmr_done) begin
               state_nxt = st_convert;
               tmr_nxt   = conv_len;
            end
         end
         st_sleep: begin
            if (wake_full || wake_br) begin
               state_nxt = st_convert;
               tmr_nxt   = slp_len;
            end
         end
      endcase
   end

   // a write in the same cycle as a fetch leaves the data valid
   assign status_nxt = wr ? `PMS_STAT_VALID : (fetch_done ? `PMS_STAT_STALE : status_r);

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         state_r   <= st_startup;
         tmr_r     <= 24'(START_CYC - 1);
         special_r <= 1'b1;
         spc_cnt_r <= 8'h00;
         status_r  <= `PMS_STAT_STALE;
      end else begin
         state_r   <= state_nxt;
         tmr_r     <= tmr_nxt;
         special_r <= special_nxt;
         spc_cnt_r <= spc_cnt_nxt;
         status_r  <= status_nxt;
      end
   end

   // temperature kept from the last full measurement
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         bridge_r <= 14'h0000;
         temp_r   <= 11'h000;
      end else if (wr) begin
         bridge_r <= bridge_code_in;
         if (special_r) begin
            temp_r <= temp_code_in;
         end
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         pkt_r <= '{status: `PMS_STAT_STALE, bridge: 14'h0000, temp: 11'h000};
         int_r <= 1'b0;
      end else begin
         pkt_r <= '{status: sleep_busy ? `PMS_STAT_STALE : status_nxt, bridge: bridge_now, temp: temp_now};
         int_r <= cfg_in.two_wire && (status_nxt == `PMS_STAT_VALID);
      end
   end

   // third stage filters the pins: a level is taken only once two samples in a row agree
   // reset to idle levels (select high, clock low) so no false edge follows
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_r <= 2'h2;
         sync2_r <= 2'h2;
         sync3_r <= 2'h2;
         pin_r   <= 2'h2;
         pin_d_r <= 2'h2;
      end else begin
         sync1_r <= {int_ss_pin_in, spi_clk_pin_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         pin_r   <= (sync2_r == sync3_r) ? sync3_r : pin_r;
         pin_d_r <= pin_r;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ss_low_cnt_r <= 9'h000;
         sclk_seen_r  <= 1'b0;
      end else if (pin_r[1]) begin
         ss_low_cnt_r <= 9'h000;
         sclk_seen_r  <= 1'b0;
      end else begin
         ss_low_cnt_r <= (ss_low_cnt_r == 9'h1ff) ? ss_low_cnt_r : ss_low_cnt_r + 9'h001;
         sclk_seen_r  <= sclk_seen_r || sclk_edge;
      end
   end

   assign result_packet_out = pkt_r;
   assign result_write_out  = wr;
   assign analog_on_out     = (state_r == st_convert);
   assign special_meas_out  = special_r;
   assign int_ss_out        = int_r;
   assign int_ss_oe_out     = cfg_in.two_wire;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (reset_in);

   startup_quiet_a: assert property (state_r == st_startup |-> !wr)
      else $error("result written during start-up");

   write_valid_a: assert property (wr |=> status_r == `PMS_STAT_VALID && pkt_r.bridge == $past(bridge_code_in))
      else $error("write did not publish valid data");

   fetch_stale_a: assert property (fetch_done && !wr |=> status_r == `PMS_STAT_STALE)
      else $error("fetch did not make status stale");

   int_match_a: assert property (int_ss_out == (cfg_in.two_wire && status_r == `PMS_STAT_VALID))
      else $error("interrupt disagrees with status");

   busy_stale_a: assert property (sleep_busy |=> pkt_r.status == `PMS_STAT_STALE)
      else $error("fetch during measurement not stale");

   fast_loop_a: assert property (wr && upd_mode && cfg_in.rate == 2'h0 |=> state_r == st_convert)
      else $error("fastest rate did not convert back to back");

   slow_pdown_a: assert property (wr && upd_mode && cfg_in.rate != 2'h0 |=> state_r == st_pdown)
      else $error("slower rate did not power down");

   sleep_hold_a: assert property (state_r == st_sleep && !wake_full && !wake_br |=> state_r == st_sleep)
      else $error("left sleep without a wake command");

   full_wake_a: assert property (state_r == st_sleep && wake_full |=> state_r == st_convert && special_r)
      else $error("full wake did not start special measurement");

   special_span_a: assert property (spc_cnt_r <= spc_limit)
      else $error("special measurement interval overrun");

   temp_keep_a: assert property (wr && !special_r |=> $stable(temp_r))
      else $error("bridge-only cycle changed temperature");

   startup_timer_a: assert property (state_r == st_startup && !tmr_done |=> tmr_r == $past(tmr_r) - 24'h1)
      else $error("start-up timer did not count down");

   startup_deaf_a: assert property (state_r == st_startup |-> !fetch_done && !wake_full && !wake_br)
      else $error("command taken during start-up");

   first_special_a: assert property (state_r == st_startup |-> special_r)
      else $error("first conversion not special");

   sleep_start_a: assert property (state_r == st_startup && tmr_done && cfg_in.sleep_mode |=> state_r == st_sleep)
      else $error("low-power mode did not sleep after start-up");

   sleep_no_pdown_a: assert property (cfg_in.sleep_mode |-> state_r != st_pdown)
      else $error("low-power mode entered periodic power-down");

   upd_no_sleep_a: assert property (upd_mode |-> state_r != st_sleep)
      else $error("periodic mode entered command sleep");

   fast_no_pdown_a: assert property (upd_mode && cfg_in.rate == 2'h0 |-> state_r != st_pdown)
      else $error("fastest rate powered down");

   pdown_quiet_a: assert property (state_r == st_pdown |-> !analog_on_out)
      else $error("analog on during power-down");

   pdown_timer_a: assert property (wr && upd_mode && cfg_in.rate != 2'h0 |=> tmr_r == $past(pdown_len))
      else $error("power-down length wrong");

   special_long_a: assert property (state_r == st_pdown && tmr_done && special_r
                                    |=> tmr_r == $past(conv_cyc + conv_cyc - 24'h1))
      else $error("special cycle not one conversion longer");

   write_pulse_a: assert property (wr |=> !wr)
      else $error("write pulse longer than one cycle");

   wake_timer_a: assert property (state_r == st_sleep && (wake_full || wake_br) |=> tmr_r == $past(slp_len))
      else $error("sleep response length wrong");

   sleep_quiet_a: assert property (state_r == st_sleep |-> !analog_on_out)
      else $error("analog on while asleep");

   sleep_done_a: assert property (wr && cfg_in.sleep_mode |=> state_r == st_sleep)
      else $error("did not power down after sleep measurement");

   full_temp_a: assert property (wr && special_r |=> temp_r == $past(temp_code_in))
      else $error("full measurement did not take temperature");

   pkt_temp_a: assert property (wr |=> pkt_r.temp == temp_r)
      else $error("packet temperature lags the write");

   sleep_valid_a: assert property (wr && cfg_in.sleep_mode |=> pkt_r.status == `PMS_STAT_VALID)
      else $error("sleep result not reported valid");

   busy_fetch_a: assert property (sleep_busy && fetch_done |=> status_r == `PMS_STAT_STALE)
      else $error("busy fetch left status valid");

   int_rise_a: assert property (wr && cfg_in.two_wire |=> int_ss_out)
      else $error("interrupt did not rise on new data");

   int_fall_a: assert property (fetch_done && !wr |=> !int_ss_out)
      else $error("interrupt stayed high after fetch");

   spi_no_int_a: assert property (!cfg_in.two_wire |-> !int_ss_out)
      else $error("interrupt driven in spi mode");

   stat_code_a: assert property (status_r == `PMS_STAT_VALID || status_r == `PMS_STAT_STALE)
      else $error("status holds an undefined code");

   spi_wake_len_a: assert property (spi_wake |-> ss_low_cnt_r >= 9'h190)
      else $error("select wake shorter than minimum");
endmodule

// ### tb/pms_host_model.sv
`timescale 1ns/100ps
module pms_host_model (
   // pins toward the device
   output logic ss_n_out,
   output logic sclk_out
);
   // select idles high on its pull-up, clock stands still low outside frames
   initial begin
      ss_n_out = 1'b1;
      sclk_out = 1'b0;
   end

   // select low, optional clocks, then release; the rise is what wakes
   task automatic frame(input int extra_ns, input int n_clk);
      ss_n_out = 1'b0;
      #3000;
      repeat (n_clk) begin
         #80 sclk_out = 1'b1;
         #80 sclk_out = 1'b0;
      end
      #(extra_ns) ss_n_out = 1'b1;
      // bus free time before the next frame
      #2000;
   endtask
endmodule

// ### tb/pms_sequencer_tb.sv
`timescale 1ns/100ps
`include "pms_params.svh"
module pms_sequencer_tb;
   import pms_pkg::*;
   // shortened counts, same ratios as the real timing apart from the much shorter start-up count
   localparam int unsigned ST      = 50;
   localparam int unsigned U4 [4]  = '{20, 60, 260, 1280};
   localparam int unsigned U1 [4]  = '{64, 200, 1000, 5000};
   localparam int unsigned SL [8]  = '{60, 180, 220, 480, 20, 60, 60, 180};
   localparam int unsigned SPC [4] = '{255, 127, 31, 15};
   logic        clock_in = 1'b0;
   logic        reset_in = 1'b1;
   pms_cfg_s    cfg      = '0;
   logic [13:0] br       = 14'h1a5c;
   logic [10:0] tp       = 11'h5a3;
   logic        wf       = 1'b0;
   logic        wb       = 1'b0;
   logic        fd       = 1'b0;
   logic        sclk;
   logic        ss_n;
   logic        int_ss;
   logic        oe;
   pms_packet_s pkt;
   logic        wr;
   logic        an;
   logic        sp;
   int          n_mismatch = 0;
   int          n_tests    = 0;
   int          n_wr       = 0;
   // shared pin: device drives it as interrupt, else the host select
   wire         pin = oe ? int_ss : ss_n;

   pms_sequencer #(.START_CYC(ST), .UPD1_CYC(U1), .UPD4_CYC(U4), .SLP_CYC(SL)) u_dut (
      .clock_in(clock_in), .reset_in(reset_in), .cfg_in(cfg),
      .bridge_code_in(br), .temp_code_in(tp),
      .wake_full_measure_read_in(wf), .wake_bridge_only_write_in(wb),
      .result_fetch_done_in(fd), .spi_clk_pin_in(sclk), .int_ss_pin_in(pin),
      .int_ss_out(int_ss), .int_ss_oe_out(oe), .result_packet_out(pkt),
      .result_write_out(wr), .analog_on_out(an), .special_meas_out(sp));

   pms_host_model u_host (.ss_n_out(ss_n), .sclk_out(sclk));

   always #10 clock_in = ~clock_in;

   always @(posedge clock_in) begin
      if (wr === 1'b1) n_wr <= n_wr + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // config is static in silicon, so every change goes through reset
   task automatic start(input pms_cfg_s c);
      @(negedge clock_in);
      reset_in = 1'b1;
      cfg = c;
      repeat (5) @(negedge clock_in);
      reset_in = 1'b0;
   endtask

   // cycles until the output write, pulses dropped after one cycle
   task automatic wt(output int n, output logic s);
      for (n = 1; n < 30000; n++) begin
         @(negedge clock_in);
         {wf, wb, fd} = 3'h0;
         if (wr === 1'b1) break;
      end
      s = sp;
   endtask

   task automatic act(input logic [2:0] v, input int exp, input string m);
      int   n;
      logic s;
      {wf, wb, fd} = v;
      wt(n, s);
      chk(n, exp, m);
   endtask

   task automatic none(input logic [2:0] v, input string m);
      int k;
      k = n_wr;
      {wf, wb, fd} = v;
      @(negedge clock_in);
      {wf, wb, fd} = 3'h0;
      repeat (500) @(negedge clock_in);
      chk(n_wr, k, m);
   endtask

   task automatic fetch;
      fd = 1'b1;
      @(negedge clock_in);
      fd = 1'b0;
      @(negedge clock_in);
      chk(pkt.status, `PMS_STAT_STALE, "stale after fetch");
      chk(int_ss, 1'b0, "int low after fetch");
   endtask

   task automatic slp(input logic [1:0] i);
      start({1'b1, i, 1'b1, 2'h0});
      if (i == 2'h0) none(3'h4, "wake in start-up");
      else repeat (ST + 2) @(negedge clock_in);
      chk(pkt.status, `PMS_STAT_STALE, "reset status");
      act(3'h4, SL[{i, 1'b1}], "full wake time");
      @(negedge clock_in);
      chk(pkt, {`PMS_STAT_VALID, br, tp}, "full packet");
      chk(int_ss, 1'b1, "int rise");
      fetch;
      tp = 11'h0c3;
      act(3'h2, SL[{i, 1'b0}], "bridge wake time");
      @(negedge clock_in);
      chk(pkt.temp, 11'h5a3, "temp reused");
      fetch;
      wf = 1'b1;
      @(negedge clock_in);
      wf = 1'b0;
      repeat (3) @(negedge clock_in);
      fetch;
      act(3'h0, SL[{i, 1'b1}] - 6, "write after busy fetch");
      tp = 11'h5a3;
      $display("test sleep %0d done", i);
   endtask

   task automatic upd(input logic c4, input logic [1:0] r);
      int   p;
      int   cv;
      int   t;
      int   k;
      logic s;
      p = c4 ? U4[r] : U1[r];
      cv = c4 ? U4[0] : U1[0];
      start({1'b0, c4, 1'b0, 1'b1, r});
      repeat (ST - 1) @(negedge clock_in);
      chk(an, 1'b0, "idle in start-up");
      wt(t, s);
      chk(s, 1'b1, "first is special");
      k = 0;
      wt(t, s);
      while (s !== 1'b1 && k < 300) begin
         chk(t, p, "period");
         k++;
         wt(t, s);
      end
      chk(t, p + cv, "special period");
      chk(k, SPC[r], "normal cycles");
      @(negedge clock_in);
      chk(pkt.status, `PMS_STAT_VALID, "valid after write");
      chk(int_ss, 1'b1, "int rise");
      fetch;
      $display("test update %0d %0d done", c4, r);
   endtask

   task automatic spi_t;
      int k;
      start(6'h30);
      repeat (ST + 2) @(negedge clock_in);
      chk(oe, 1'b0, "pin is select");
      none(3'h2, "bridge wake in spi");
      k = n_wr;
      // 4 us low: too short to wake
      u_host.frame(1000, 0);
      chk(n_wr, k, "short select");
      u_host.frame(6000, 0);
      repeat (SL[5] + 20) @(negedge clock_in);
      chk(n_wr, k + 1, "select wake");
      chk(pkt.status, `PMS_STAT_VALID, "valid");
      u_host.frame(0, 32);
      repeat (10) @(negedge clock_in);
      chk(pkt.status, `PMS_STAT_STALE, "fetch stale");
      $display("test spi done");
   endtask

   initial begin
      for (int i = 0; i < 4; i++) begin
         slp(i[1:0]);
      end
      spi_t;
      upd(1'b0, 2'h0);
      for (int r = 0; r < 4; r++) begin
         upd(1'b1, r[1:0]);
      end
      wrap_up;
   end

   // whole run is about 1.3 ms of simulated time; limit keeps a hang under 90k cycles
   initial begin
      #1800000;
      n_mismatch++;
      wrap_up;
   end
endmodule
